// File: src/svsr_status_regs.sv
// Supervisor status register bank with an AXI4-Lite slave and an interrupt.
//
// Notes on behaviour
// - regulator fault sets fault bit 6, W1C.
// - oscillator fault sets fault bit 4, W1C.
// - address pin short bit 3, open bit 2.
// - state bit 7 shows fail-safe state.
// - state bit 5 shows supply pin level.
// - state bit 4 shows interrupt pin level.
// - state bit 3 shows sleep pin level.
// - state bit 2 shows activate pin level.
// - state bit 1 shows rail-tag pin level.
// - test bit 5 shows single error corrected.
// - test bit 4 shows double error detected.
// - test bit 3 volatile memory test fail.
// - test bit 2 non-volatile memory test fail.
// - test bit 1 logic test fail.
// - test bit 0 analog test fail.
// - off bits 5:0 show channel below threshold.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module svsr_status_regs
  import svsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SVSR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SVSR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire svsr_fault_ev_t fault_ev,
  input wire logic safe_state_flag,
  input wire logic selftest_done_state,
  input wire svsr_test_t test_result,
  input wire logic [SVSR_NCH-1:0] channel_off_flag,
  input wire svsr_pins_t pins_raw,
  output logic irq_q
);

  // Write channel state: address and data may arrive in either order.
  logic aw_held_q;
  logic w_held_q;
  logic [SVSR_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  // Read-only snapshot registers, updated every cycle.
  logic [7:0] state_q;
  logic [7:0] test_q;
  logic [7:0] off_q;
  // Interrupt enable register.
  logic [7:0] irq_en_q;
  // Synchronised pin levels.
  svsr_pins_t pins_s;
  // Sticky fault flags and their clear strobes.
  logic [7:0] fault_flags;
  logic [7:0] fault_set;
  logic [7:0] fault_clr;
  // Write commit and decoded index.
  logic wr_go;
  logic [8:0] wr_idx;
  logic lane0_wr;

  // Pin levels go through two flops before they are shown.
  svsr_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(pins_raw),
    .pin_sync(pins_s)
  );

  // Write commits once both halves are held and no response is pending.
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx = svsr_index(awaddr_q);
  assign lane0_wr = wr_go && wstrb_q[0];

  // Event set vector in register layout.
  always_comb
  begin
    fault_set = SVSR_ZERO8;
    fault_set[SVSR_F_REG] = fault_ev.internal_regulator_fault;
    fault_set[SVSR_F_OSC] = fault_ev.oscillator_fault;
    fault_set[SVSR_F_SHORT] = fault_ev.addr_pin_short_fault;
    fault_set[SVSR_F_OPEN] = fault_ev.addr_pin_open_fault;
  end

  // Both the fault register and the interrupt clear register clear a fault flag.
  always_comb
  begin
    fault_clr = SVSR_ZERO8;
    if (lane0_wr && (wr_idx[7:0] == SVSR_IDX_FAULT || wr_idx[7:0] == SVSR_IDX_IRQ_CLR) && !wr_idx[8])
    begin
      fault_clr = wdata_q[7:0] & SVSR_FAULT_MASK;
    end
  end

  // Reserved bits get no flop and read as zero.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_fault
      if (SVSR_FAULT_MASK[gi])
      begin : g_used
        svsr_w1c u_flag (
          .aclk(aclk),
          .aresetn(aresetn),
          .set_i(fault_set[gi]),
          .clr_i(fault_clr[gi]),
          .flag_q(fault_flags[gi])
        );
      end
      else
      begin : g_rsvd
        assign fault_flags[gi] = 1'b0;
      end
    end
  endgenerate

  // Live state register composed from internal states and synchronised pins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= SVSR_ZERO8;
    end
    else
    begin
      state_q[SVSR_S_SAFE] <= safe_state_flag;
      state_q[SVSR_S_DONE] <= selftest_done_state;
      state_q[SVSR_S_SUPPLY] <= pins_s.supply_pin_level;
      state_q[SVSR_S_IRQ] <= pins_s.irq_pin_level;
      state_q[SVSR_S_SLEEP] <= pins_s.sleep_pin_level;
      state_q[SVSR_S_ACT] <= pins_s.activate_pin_level;
      state_q[SVSR_S_RAIL] <= pins_s.rail_tag_pin_level;
      state_q[0] <= 1'b0;
    end
  end

  // Self-test results and channel off flags; writes never touch them.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      test_q <= SVSR_ZERO8;
      off_q <= SVSR_ZERO8;
    end
    else
    begin
      test_q <= {2'b00, test_result};
      off_q <= {2'b00, channel_off_flag};
    end
  end

  // Interrupt enable is the only plain read/write register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_en_q <= SVSR_ZERO8;
    end
    else if (lane0_wr && !wr_idx[8] && wr_idx[7:0] == SVSR_IDX_IRQ_EN)
    begin
      irq_en_q <= wdata_q[7:0] & SVSR_FAULT_MASK;
    end
  end

  // Level interrupt while any enabled flag is set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(fault_flags & irq_en_q);
    end
  end

  // Write address and data capture; each is taken once and held until commit.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Ready flops: offered only while the matching holding slot is empty.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Write response; read-only registers answer OKAY but keep their value.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SVSR_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      case (wr_idx)
        {1'b0, SVSR_IDX_FAULT}, {1'b0, SVSR_IDX_STATE}, {1'b0, SVSR_IDX_TEST}, {1'b0, SVSR_IDX_OFF},
        {1'b0, SVSR_IDX_IRQ_STAT}, {1'b0, SVSR_IDX_IRQ_EN}, {1'b0, SVSR_IDX_IRQ_CLR}:
          s_axi_bresp <= SVSR_RESP_OKAY;
        default:
          s_axi_bresp <= SVSR_RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path: one cycle from the address handshake to rvalid.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SVSR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= SVSR_RESP_OKAY;
        case (svsr_index(s_axi_araddr))
          {1'b0, SVSR_IDX_FAULT}: s_axi_rdata <= {24'h0, fault_flags};
          {1'b0, SVSR_IDX_IRQ_STAT}: s_axi_rdata <= {24'h0, fault_flags};
          {1'b0, SVSR_IDX_STATE}: s_axi_rdata <= {24'h0, state_q};
          {1'b0, SVSR_IDX_TEST}: s_axi_rdata <= {24'h0, test_q};
          {1'b0, SVSR_IDX_OFF}: s_axi_rdata <= {24'h0, off_q};
          {1'b0, SVSR_IDX_IRQ_EN}: s_axi_rdata <= {24'h0, irq_en_q};
          {1'b0, SVSR_IDX_IRQ_CLR}: s_axi_rdata <= '0;
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= SVSR_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Assertions.
  // A rise that is held for three samples must reach the state register.
  sequence pin_rise_s;
    $rose(pins_raw.sleep_pin_level) ##1 pins_raw.sleep_pin_level ##1 pins_raw.sleep_pin_level;
  endsequence

  sleep_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_rise_s |=> state_q[SVSR_S_SLEEP]) else $error("sleep level not shown after sync");
  safe_state_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 state_q[SVSR_S_SAFE] == $past(safe_state_flag)) else $error("safe state bit mismatch");
  reg_fault_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_ev.internal_regulator_fault |=> fault_flags[SVSR_F_REG]) else $error("regulator flag not set");
  osc_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_flags[SVSR_F_OSC] && !fault_clr[SVSR_F_OSC] |=> fault_flags[SVSR_F_OSC]) else $error("osc flag lost");
  addr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_clr[SVSR_F_SHORT] && !fault_set[SVSR_F_SHORT] |=> !fault_flags[SVSR_F_SHORT]) else $error("short not cleared");
  test_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 test_q[SVSR_T_ANALOG] == $past(test_result.analog_test_fail)) else $error("analog bit mismatch");
  off_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 off_q == {2'b00, $past(channel_off_flag)}) else $error("off flags mismatch");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq_q == |($past(fault_flags) & $past(irq_en_q))) else $error("interrupt level wrong");
  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered in one cycle");

  // The supply pin takes the same two-flop path, so it gets the same latency check.
  sequence supply_rise_s;
    $rose(pins_raw.supply_pin_level) ##1 pins_raw.supply_pin_level ##1 pins_raw.supply_pin_level;
  endsequence

  supply_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
    supply_rise_s |=> state_q[SVSR_S_SUPPLY]) else $error("supply level not shown after sync");
  done_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 state_q[SVSR_S_DONE] == $past(selftest_done_state)) else $error("self-test done bit mismatch");
  sec_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 test_q[SVSR_T_SEC] == $past(test_result.single_err_corrected)) else $error("single error bit mismatch");
  open_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_ev.addr_pin_open_fault |=> fault_flags[SVSR_F_OPEN]) else $error("open flag not set");
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid) else $error("write not answered after commit");
  ro_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lane0_wr && wr_idx == {1'b0, SVSR_IDX_TEST} |=> test_q == {2'b00, $past(test_result)})
    else $error("write changed the self-test register");

endmodule // svsr_status_regs

// File: shared/svsr_pkg.sv
// Package of offsets, field positions, reset values and carrier types for the supervisor status registers.
package svsr_pkg;

  // Register indices; the printed offsets are not all multiples of four, so the byte address is four times these.
  localparam logic [7:0] SVSR_IDX_FAULT = 8'h24;
  localparam logic [7:0] SVSR_IDX_STATE = 8'h30;
  localparam logic [7:0] SVSR_IDX_TEST = 8'h31;
  localparam logic [7:0] SVSR_IDX_OFF = 8'h32;
  // Interrupt registers, placed above the documented ones.
  localparam logic [7:0] SVSR_IDX_IRQ_STAT = 8'h40;
  localparam logic [7:0] SVSR_IDX_IRQ_EN = 8'h41;
  localparam logic [7:0] SVSR_IDX_IRQ_CLR = 8'h42;
  localparam int SVSR_ADDR_W = 10;

  // Field positions of the internal fault register.
  localparam int SVSR_F_REG = 6;
  localparam int SVSR_F_OSC = 4;
  localparam int SVSR_F_SHORT = 3;
  localparam int SVSR_F_OPEN = 2;
  localparam logic [7:0] SVSR_FAULT_MASK = 8'h5C;

  // Field positions of the state register.
  localparam int SVSR_S_SAFE = 7;
  localparam int SVSR_S_DONE = 6;
  localparam int SVSR_S_SUPPLY = 5;
  localparam int SVSR_S_IRQ = 4;
  localparam int SVSR_S_SLEEP = 3;
  localparam int SVSR_S_ACT = 2;
  localparam int SVSR_S_RAIL = 1;

  // Field positions of the self-test register.
  localparam int SVSR_T_SEC = 5;
  localparam int SVSR_T_DED = 4;
  localparam int SVSR_T_VM = 3;
  localparam int SVSR_T_NVM = 2;
  localparam int SVSR_T_LOGIC = 1;
  localparam int SVSR_T_ANALOG = 0;

  // Channel count and pin count.
  localparam int SVSR_NCH = 6;
  localparam int SVSR_NPIN = 5;
  localparam logic [7:0] SVSR_ZERO8 = 8'h00;
  localparam logic [1:0] SVSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] SVSR_RESP_SLVERR = 2'h2;

  // Internal event inputs from the detectors and self-test engine.
  typedef struct packed {
    logic internal_regulator_fault;
    logic oscillator_fault;
    logic addr_pin_short_fault;
    logic addr_pin_open_fault;
  } svsr_fault_ev_t;

  // Self-test and configuration load results.
  typedef struct packed {
    logic single_err_corrected;
    logic double_err_detected;
    logic volatile_mem_test_fail;
    logic nonvolatile_mem_test_fail;
    logic logic_test_fail;
    logic analog_test_fail;
  } svsr_test_t;

  // Asynchronous pin levels, in state register order from bit 5 down to bit 1.
  typedef struct packed {
    logic supply_pin_level;
    logic irq_pin_level;
    logic sleep_pin_level;
    logic activate_pin_level;
    logic rail_tag_pin_level;
  } svsr_pins_t;

  // Maps a byte address to a register index; non-word addresses give an invalid index.
  function automatic logic [8:0] svsr_index(input logic [SVSR_ADDR_W-1:0] addr);
    svsr_index = (addr[1:0] == 2'h0) ? {1'b0, addr[SVSR_ADDR_W-1:2]} : 9'h1FF;
  endfunction

endpackage

// File: src/svsr_sync.sv
// Two-flop synchroniser bank for the pin levels.
`timescale 1ns/1ps
module svsr_sync
  import svsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SVSR_NPIN-1:0] pin_raw,
  output logic [SVSR_NPIN-1:0] pin_sync
);

  // First stage; read only by the second stage.
  logic [SVSR_NPIN-1:0] meta_q;

  // One two-stage chain per pin, built by a generate loop.
  genvar g;
  generate
    for (g = 0; g < SVSR_NPIN; g++)
    begin : g_chain
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta_q[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= pin_raw[g];
          pin_sync[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule // svsr_sync

// File: src/svsr_w1c.sv
// One sticky write-one-to-clear flag where a set wins over a clear.
`timescale 1ns/1ps
module svsr_w1c
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_q
);

  // Set has priority so an event in the clearing cycle is kept.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_q <= 1'b0;
    end
    else if (set_i)
    begin
      flag_q <= 1'b1;
    end
    else if (clr_i)
    begin
      flag_q <= 1'b0;
    end
  end

endmodule // svsr_w1c

// File: tb/tb_supervisor_status_regs.sv
// Self-checking bench for the supervisor status register bank.
`timescale 1ns/1ps
module tb_supervisor_status_regs
  import svsr_pkg::*;
;
  // Bus handshake and payload signals driven or watched by the bench.
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq_q;
  logic [SVSR_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  // Status sources feeding the bank.
  svsr_fault_ev_t fault_ev;
  logic safe_state_flag, selftest_done_state;
  svsr_test_t test_result;
  logic [SVSR_NCH-1:0] channel_off_flag;
  svsr_pins_t pins_raw;
  int fail_count, n_compared;
  // Fault bit expected for each event input, in struct order.
  logic [7:0] fb [4];
  localparam logic [1:0] rok = SVSR_RESP_OKAY;
  localparam logic [1:0] rerr = SVSR_RESP_SLVERR;

  svsr_status_regs uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fault_ev(fault_ev), .safe_state_flag(safe_state_flag),
    .selftest_done_state(selftest_done_state), .test_result(test_result),
    .channel_off_flag(channel_off_flag), .pins_raw(pins_raw), .irq_q(irq_q)
  );

  // Free-running 100 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Compares a seen value with the expected one; four-state equality keeps unknowns visible.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, s, e);
    end
  endtask

  // One clock edge of a bounded wait; a hung bus ends the run instead of stalling it.
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t bus timeout", $time);
      tally_and_finish();
    end
  endtask

  // Registers are word aligned, so the byte address is four times the index.
  function automatic logic [SVSR_ADDR_W-1:0] ba(input logic [7:0] i);
    ba = {i, 2'b00};
  endfunction

  // Write: address and data offered together, each released when taken, then the response.
  task automatic wr(input logic [SVSR_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic pa, pw;
    n = 0;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw)
    begin
      step(n);
      if (pa && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do step(n); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  // Read: address held until taken, data and response taken at the rvalid edge.
  task automatic rd(input logic [SVSR_ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(n); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // Main sequence.
  initial
  begin
    fb = '{8'h40, 8'h10, 8'h08, 8'h04};
    fail_count = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    wstrb = 4'h0;
    fault_ev = 4'h0;
    {safe_state_flag, selftest_done_state} = 2'h0;
    test_result = 6'h00;
    channel_off_flag = 6'h00;
    pins_raw = 5'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Fault, state, self-test, off and enable registers read zero straight after reset.
    rd(ba(SVSR_IDX_FAULT), 32'h0, rok);
    rd(ba(SVSR_IDX_STATE), 32'h0, rok);
    rd(ba(SVSR_IDX_TEST), 32'h0, rok);
    rd(ba(SVSR_IDX_OFF), 32'h0, rok);
    rd(ba(SVSR_IDX_IRQ_EN), 32'h0, rok);
    // Each fault event latches its own bit; only a one written to that bit clears it.
    for (int i = 0; i < 4; i++)
    begin
      fault_ev <= 4'h8 >> i;
      @(posedge aclk);
      fault_ev <= 4'h0;
      rd(ba(SVSR_IDX_FAULT), {24'h0, fb[i]}, rok);
      rd(ba(SVSR_IDX_IRQ_STAT), {24'h0, fb[i]}, rok);
      chk({31'h0, irq_q}, 32'h0);
      wr(ba(SVSR_IDX_FAULT), {24'h0, ~fb[i]}, rok);
      rd(ba(SVSR_IDX_FAULT), {24'h0, fb[i]}, rok);
      wr(ba(SVSR_IDX_FAULT), {24'h0, fb[i]}, rok);
      rd(ba(SVSR_IDX_FAULT), 32'h0, rok);
    end
    // Walking one through the state sources; pins need the synchroniser delay.
    for (int i = 0; i < 7; i++)
    begin
      {safe_state_flag, selftest_done_state, pins_raw} <= 7'h40 >> i;
      repeat (4) @(posedge aclk);
      rd(ba(SVSR_IDX_STATE), 32'h80 >> i, rok);
    end
    wr(ba(SVSR_IDX_STATE), 32'hFF, rok);
    rd(ba(SVSR_IDX_STATE), 32'h02, rok);
    // Walking one through the self-test results.
    for (int i = 0; i < 6; i++)
    begin
      test_result <= 6'h20 >> i;
      repeat (2) @(posedge aclk);
      rd(ba(SVSR_IDX_TEST), 32'h20 >> i, rok);
    end
    wr(ba(SVSR_IDX_TEST), 32'hFF, rok);
    rd(ba(SVSR_IDX_TEST), 32'h01, rok);
    // Walking one through the channel off flags.
    for (int i = 0; i < 6; i++)
    begin
      channel_off_flag <= 6'h01 << i;
      repeat (2) @(posedge aclk);
      rd(ba(SVSR_IDX_OFF), 32'h01 << i, rok);
    end
    wr(ba(SVSR_IDX_OFF), 32'h00, rok);
    rd(ba(SVSR_IDX_OFF), 32'h20, rok);
    // Unmapped and misaligned places answer with an error and read zero.
    rd(ba(8'h10), 32'h0, rerr);
    rd(10'h091, 32'h0, rerr);
    wr(ba(8'h10), 32'hFF, rerr);
    // Interrupt: raised when enabled, masked, unmasked, then cleared.
    wr(ba(SVSR_IDX_IRQ_EN), 32'h40, rok);
    rd(ba(SVSR_IDX_IRQ_EN), 32'h40, rok);
    fault_ev <= 4'h8;
    @(posedge aclk);
    fault_ev <= 4'h0;
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_q}, 32'h1);
    wr(ba(SVSR_IDX_IRQ_EN), 32'h00, rok);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_q}, 32'h0);
    wr(ba(SVSR_IDX_IRQ_EN), 32'h40, rok);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_q}, 32'h1);
    wr(ba(SVSR_IDX_IRQ_CLR), 32'h40, rok);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_q}, 32'h0);
    rd(ba(SVSR_IDX_IRQ_CLR), 32'h0, rok);
    rd(ba(SVSR_IDX_FAULT), 32'h0, rok);
    tally_and_finish();
  end
endmodule // tb_supervisor_status_regs
